/* File: shared/pmt_consts.svh */
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// ==========================================
// register byte offsets
`define PMT_OFS_CONTROL 12'h000
`define PMT_OFS_COUNT_LOW 12'h004
`define PMT_OFS_COUNT_HIGH 12'h008
`define PMT_OFS_PERIOD_LOW 12'h00c
`define PMT_OFS_PERIOD_HIGH 12'h010
`define PMT_OFS_IRQ_STATUS 12'h014
`define PMT_OFS_IRQ_MASK 12'h018

// ==========================================
// control field positions and the irq status match flag bit
`define PMT_BIT_RUN 0
`define PMT_BIT_CLK_SRC 1
`define PMT_BIT_ASYNC 2
`define PMT_BIT_PS_LO 3
`define PMT_BIT_PS_HI 4
`define PMT_BIT_ONE_SHOT 5
`define PMT_BIT_TRIG_RST_DIS 6
`define PMT_BIT_SLEEP_RUN 7
`define PMT_BIT_MATCH_FLAG 0

// ==========================================
// reset values
`define PMT_RST_CONTROL 8'h00
`define PMT_RST_COUNT 16'h0000
`define PMT_RST_PERIOD 16'hffff
`define PMT_RST_IRQ 8'h00

// ==========================================
// timing: clock 50 MHz, instruction cycle is four clock phases
`define PMT_CLK_NS 20
`define PMT_QPHASES 4
`define PMT_QCNT_LAST 2'h3

`endif

/* File: shared/pmt_pkg.sv */
package pmt_pkg;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pmt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmt_apb_rsp_t;

  typedef enum logic [2:0] {
    PMT_REG_CONTROL = 3'b000,
    PMT_REG_COUNT_LOW = 3'b001,
    PMT_REG_COUNT_HIGH = 3'b010,
    PMT_REG_PERIOD_LOW = 3'b011,
    PMT_REG_PERIOD_HIGH = 3'b100,
    PMT_REG_IRQ_STATUS = 3'b101,
    PMT_REG_IRQ_MASK = 3'b110,
    PMT_REG_NONE = 3'b111
  } pmt_reg_t;

  typedef struct packed {
    logic [7:0] control;
    logic [15:0] count;
    logic [15:0] period;
    logic [7:0] high_buffer;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [2:0] prescale;
    logic [1:0] qphase;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic [31:0] prdata;
    logic [7:0] snap_high;
    logic trigger;
    logic wake;
  } pmt_state_t;

endpackage

/* File: rtl/pmt_timer.sv */
// How it works
// - The counter advances only while timer_run (control bit 0) is set, and clearing it stops counting.
// - While SLEEP_I is high the timer runs only as an asynchronous counter (bits 1 and 2 set) and only if sleep_run_enable (control bit 7) is set.
// - An incoming special event trigger clears the count only while trigger_reset_disable (bit 6) is 0.
// - one_shot_select (bit 5) picks single-shot when 1 and continuous counting when 0.
// - prescale_select (bits 4:3) divides the count clock by 1, 2, 4 or 8 for codes 00, 01, 10, 11.
// - async_select (bit 2) takes the external pin unsynchronized at 1 and synchronized at 0, ignored for internal.
// - clock_source_select (bit 1) counts the external pin when 1 and the instruction-cycle clock when 0.
// - The count is two bytes, and the mapped low byte is the live low byte, read and written directly.
// - The live high byte moves only through a buffer register that transfers with each low-byte access.
// - Each byte counts 00h to FFh and a low-byte overflow carries into the high byte.
// - When the count equals the period pair it rolls to zero and sets period_match_flag.
// - Synchronous timer, synchronous counter and asynchronous counter configurations are all supported.
// - In timer configuration the count steps on the first quarter-phase of each instruction cycle.
// - A period match while in Sleep raises the wake output.
// - Each period match pulses the special event trigger output, so the block works as a delay timer.
`timescale 1ns/10ps
`default_nettype none
`include "pmt_consts.svh"

module pmt_timer
  import pmt_pkg::*;
(
  input wire logic CLK_I, // 50 MHz system clock
  input wire logic RSTN_I, // async reset, active low
  input wire logic [11:0] PADDR_I, // apb address
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb enable
  input wire logic PWRITE_I, // apb direction
  input wire logic [31:0] PWDATA_I, // apb write data
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error on unmapped address
  input wire logic EXT_COUNT_I, // ext_count_input pin
  input wire logic SLEEP_I, // device is in sleep
  input wire logic TRIG_RESET_I, // incoming special event trigger
  output logic TRIG_O, // outgoing special event trigger pulse
  output logic WAKE_O, // wake request pulse
  output logic IRQ_O // level interrupt
);

  // ==========================================
  // address decode
  function automatic pmt_reg_t decode(input logic [11:0] addr);
    pmt_reg_t r;
    r = PMT_REG_NONE;
    if (addr == `PMT_OFS_CONTROL) begin
      r = PMT_REG_CONTROL;
    end else if (addr == `PMT_OFS_COUNT_LOW) begin
      r = PMT_REG_COUNT_LOW;
    end else if (addr == `PMT_OFS_COUNT_HIGH) begin
      r = PMT_REG_COUNT_HIGH;
    end else if (addr == `PMT_OFS_PERIOD_LOW) begin
      r = PMT_REG_PERIOD_LOW;
    end else if (addr == `PMT_OFS_PERIOD_HIGH) begin
      r = PMT_REG_PERIOD_HIGH;
    end else if (addr == `PMT_OFS_IRQ_STATUS) begin
      r = PMT_REG_IRQ_STATUS;
    end else if (addr == `PMT_OFS_IRQ_MASK) begin
      r = PMT_REG_IRQ_MASK;
    end
    return r;
  endfunction

  pmt_apb_req_t req;
  pmt_apb_rsp_t rsp;
  pmt_state_t st;
  pmt_state_t next_st;
  pmt_reg_t sel_reg;
  logic setup_phase;
  logic access_done;
  logic do_write;
  logic do_read;

  assign req = '{paddr: PADDR_I, psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I, pwdata: PWDATA_I};
  assign sel_reg = decode(req.paddr);
  assign setup_phase = req.psel && !req.penable;
  assign access_done = req.psel && req.penable;
  assign do_write = access_done && req.pwrite && (sel_reg != PMT_REG_NONE);
  assign do_read = access_done && !req.pwrite;

  // zero wait states: every access phase completes in its first cycle
  assign rsp.pready = req.psel && req.penable;
  assign rsp.pslverr = access_done && (sel_reg == PMT_REG_NONE);
  assign rsp.prdata = st.prdata;

  assign PRDATA_O = rsp.prdata;
  assign PREADY_O = rsp.pready;
  assign PSLVERR_O = rsp.pslverr;
  assign TRIG_O = st.trigger;
  assign WAKE_O = st.wake;
  assign IRQ_O = |(st.irq_status & st.irq_mask);

  // ==========================================
  // next state
  logic run;
  logic ext_src;
  logic async_sel;
  logic one_shot;
  logic [1:0] ps_sel;
  logic q1_tick;
  logic ext_edge;
  logic src_tick;
  logic running;
  logic [2:0] ps_last;
  logic step;
  logic match;
  logic trig_clear;

  always_comb begin
    next_st = st;
    run = st.control[`PMT_BIT_RUN];
    ext_src = st.control[`PMT_BIT_CLK_SRC];
    async_sel = st.control[`PMT_BIT_ASYNC];
    one_shot = st.control[`PMT_BIT_ONE_SHOT];
    ps_sel = st.control[`PMT_BIT_PS_HI:`PMT_BIT_PS_LO];

    // quarter-phase divider; the tick marks the first phase
    next_st.qphase = st.qphase + 2'h1;
    q1_tick = (st.qphase == `PMT_QCNT_LAST);

    // synchronized path uses the second flop; async path sees the raw pin
    next_st.ext_sync1 = EXT_COUNT_I;
    next_st.ext_sync2 = st.ext_sync1;
    next_st.ext_prev = async_sel ? EXT_COUNT_I : st.ext_sync2;
    ext_edge = async_sel ? (EXT_COUNT_I && !st.ext_prev) : (st.ext_sync2 && !st.ext_prev);

    // timer, sync counter or async counter
    src_tick = ext_src ? ext_edge : q1_tick;

    // only the unsynchronized pin keeps counting in sleep, the core clocks stop
    running = run;
    if (SLEEP_I) begin
      running = run && st.control[`PMT_BIT_SLEEP_RUN] && ext_src && async_sel;
    end

    // prescaler: divide by 1, 2, 4, 8
    case (ps_sel)
      2'b00: ps_last = 3'h0;
      2'b01: ps_last = 3'h1;
      2'b10: ps_last = 3'h3;
      default: ps_last = 3'h7;
    endcase
    step = 1'b0;
    if (running && src_tick) begin
      if (st.prescale >= ps_last) begin
        next_st.prescale = 3'h0;
        step = 1'b1;
      end else begin
        next_st.prescale = st.prescale + 3'h1;
      end
    end

    match = 1'b0;
    next_st.trigger = 1'b0;
    next_st.wake = 1'b0;
    if (step) begin
      if (st.count == st.period) begin
        match = 1'b1;
        next_st.count = `PMT_RST_COUNT;
      end else begin
        next_st.count = st.count + 16'h0001; // low carry into high
      end
    end
    if (match) begin
      next_st.trigger = 1'b1;
      next_st.wake = SLEEP_I;
      if (one_shot) begin
        next_st.control[`PMT_BIT_RUN] = 1'b0;
      end
    end

    trig_clear = TRIG_RESET_I && !st.control[`PMT_BIT_TRIG_RST_DIS];
    if (trig_clear) begin
      next_st.count = `PMT_RST_COUNT;
      next_st.prescale = 3'h0;
    end

    // ==========================================
    // register reads: data captured in setup, side effects at completion
    if (setup_phase) begin
      next_st.prdata = 32'h0000_0000;
      next_st.snap_high = st.count[15:8];
      if (sel_reg == PMT_REG_CONTROL) begin
        next_st.prdata = {24'h00_0000, st.control};
      end else if (sel_reg == PMT_REG_COUNT_LOW) begin
        next_st.prdata = {24'h00_0000, st.count[7:0]};
      end else if (sel_reg == PMT_REG_COUNT_HIGH) begin
        next_st.prdata = {24'h00_0000, st.high_buffer};
      end else if (sel_reg == PMT_REG_PERIOD_LOW) begin
        next_st.prdata = {24'h00_0000, st.period[7:0]};
      end else if (sel_reg == PMT_REG_PERIOD_HIGH) begin
        next_st.prdata = {24'h00_0000, st.period[15:8]};
      end else if (sel_reg == PMT_REG_IRQ_STATUS) begin
        next_st.prdata = {24'h00_0000, st.irq_status};
      end else if (sel_reg == PMT_REG_IRQ_MASK) begin
        next_st.prdata = {24'h00_0000, st.irq_mask};
      end
    end

    if (do_read) begin
      if (sel_reg == PMT_REG_COUNT_LOW) begin
        // high byte as it stood with the low byte that was returned
        next_st.high_buffer = st.snap_high;
      end else if (sel_reg == PMT_REG_IRQ_STATUS) begin
        // only bits actually returned are cleared, later events survive
        next_st.irq_status = st.irq_status & ~st.prdata[7:0];
      end
    end

    // ==========================================
    // register writes override the counter in the same cycle
    if (do_write) begin
      if (sel_reg == PMT_REG_CONTROL) begin
        next_st.control = req.pwdata[7:0];
      end else if (sel_reg == PMT_REG_COUNT_LOW) begin
        next_st.count = {st.high_buffer, req.pwdata[7:0]};
        next_st.prescale = 3'h0;
      end else if (sel_reg == PMT_REG_COUNT_HIGH) begin
        next_st.high_buffer = req.pwdata[7:0];
      end else if (sel_reg == PMT_REG_PERIOD_LOW) begin
        next_st.period[7:0] = req.pwdata[7:0];
      end else if (sel_reg == PMT_REG_PERIOD_HIGH) begin
        next_st.period[15:8] = req.pwdata[7:0];
      end else if (sel_reg == PMT_REG_IRQ_MASK) begin
        next_st.irq_mask = req.pwdata[7:0];
      end
    end

    // set wins over a clearing read in the same cycle
    if (match) begin
      next_st.irq_status[`PMT_BIT_MATCH_FLAG] = 1'b1;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st.control <= `PMT_RST_CONTROL;
      st.count <= `PMT_RST_COUNT;
      st.period <= `PMT_RST_PERIOD;
      st.high_buffer <= 8'h00;
      st.irq_status <= `PMT_RST_IRQ;
      st.irq_mask <= `PMT_RST_IRQ;
      st.prescale <= 3'h0;
      st.qphase <= 2'h0;
      st.ext_sync1 <= 1'b0;
      st.ext_sync2 <= 1'b0;
      st.ext_prev <= 1'b0;
      st.prdata <= 32'h0000_0000;
      st.snap_high <= 8'h00;
      st.trigger <= 1'b0;
      st.wake <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

/* File: bench/pmt_timer_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module pmt_timer_properties (
  input wire logic CLK_I, // clock
  input wire logic RSTN_I, // reset, low
  input wire logic [11:0] PADDR_I, // address
  input wire logic PSEL_I, // select
  input wire logic PENABLE_I, // enable
  input wire logic PWRITE_I, // direction
  input wire logic [31:0] PRDATA_O, // read data
  input wire logic PREADY_O, // ready
  input wire logic PSLVERR_O, // error
  input wire logic SLEEP_I, // sleep
  input wire logic TRIG_O, // trigger out
  input wire logic WAKE_O // wake out
);
  // ====================
  // bus and event checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  chk_ready_access: assert property (PREADY_O == (PSEL_I && PENABLE_I))
    else $error("ready off access");
  chk_trig_pulse: assert property (TRIG_O |=> !TRIG_O)
    else $error("trigger too long");
  chk_wake_sleep: assert property (WAKE_O |-> TRIG_O && $past(SLEEP_I))
    else $error("wake without sleep match");
  chk_match_wakes: assert property (TRIG_O && $past(SLEEP_I) |-> WAKE_O)
    else $error("sleep match without wake");
  chk_read_upper: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
    else $error("read upper bits set");
  chk_err_unmapped: assert property (PSEL_I && PENABLE_I && PADDR_I > 12'h018 |-> PSLVERR_O)
    else $error("no error on hole");
  chk_err_mapped: assert property (PSEL_I && PENABLE_I && PADDR_I <= 12'h018 && PADDR_I[1:0] == 2'h0
    |-> !PSLVERR_O)
    else $error("error on register");
  chk_err_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("hole read not zero");
  cover property (TRIG_O);
  cover property (WAKE_O);
  cover property (PSLVERR_O);
endmodule
bind pmt_timer pmt_timer_properties u_chk (.CLK_I, .RSTN_I, .PADDR_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PRDATA_O, .PREADY_O, .PSLVERR_O, .SLEEP_I, .TRIG_O, .WAKE_O);
`default_nettype wire

/* File: bench/pmt_ext_source.sv */
`timescale 1ns/10ps
`default_nettype none
module pmt_ext_source (
  input wire logic clk_i, // bench clock
  input wire logic go_i, // start a burst
  input wire logic [7:0] pulses_i, // rising edges wanted
  output logic pin_o, // count pin
  output logic busy_o // burst running
);
  logic [8:0] left;
  logic [1:0] div;
  initial begin
    pin_o = 1'b0;
    left = 9'h0;
    div = 2'h0;
  end
  assign busy_o = left != 9'h0;
  // ====================
  // three clocks a level so the synchronized path never misses an edge
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= {pulses_i, 1'b0};
      div <= 2'h0;
    end else if (left != 9'h0) begin
      div <= div + 2'h1;
      if (div == 2'h2) begin
        div <= 2'h0;
        pin_o <= !pin_o;
        left <= left - 9'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, sleep = 0, trst = 0, go = 0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [7:0] npl = 8'h0;
  logic prdy, perr, pin, trig, wake, irq, busy;
  int bad_count = 0, check_count = 0, cycles = 0, trigs = 0, wakes = 0, n, t0;
  pmt_timer dut (.CLK_I(clk), .RSTN_I(rstn), .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .EXT_COUNT_I(pin), .SLEEP_I(sleep), .TRIG_RESET_I(trst), .TRIG_O(trig), .WAKE_O(wake), .IRQ_O(irq));
  pmt_ext_source src (.clk_i(clk), .go_i(go), .pulses_i(npl), .pin_o(pin), .busy_o(busy));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    trigs += (trig === 1'b1);
    wakes += (wake === 1'b1);
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ====================
  // shared tasks
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, d);
  endtask
  task rdc(input string s, input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 8'h0);
    chk(s, {24'h0, e}, rd);
  endtask
  task pulses(input logic [7:0] k);
    @(posedge clk);
    npl <= k; go <= 1;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task kick;
    @(posedge clk) trst <= 1;
    @(posedge clk) trst <= 0;
  endtask
  task gap;
    while (trig !== 1'b1) @(posedge clk);
    n = 0;
    do begin @(posedge clk); n++; end while (trig !== 1'b1 && n < 600);
  endtask
  task chk_irq(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // ====================
  // scenarios
  task t_regs;
    rdc("control", 12'h000, 8'h00);
    rdc("period low", 12'h00c, 8'hff);
    rdc("period high", 12'h010, 8'hff);
    rdc("mask", 12'h018, 8'h00);
    wr(12'h000, 8'hfe);
    rdc("control rw", 12'h000, 8'hfe);
    wr(12'h000, 8'h00);
    apb(0, 12'h01c, 8'h0);
    chk("hole err", 1, {31'h0, er});
  endtask
  task t_bytes;
    wr(12'h008, 8'h12); wr(12'h004, 8'h34);
    wr(12'h008, 8'h00);
    rdc("low", 12'h004, 8'h34);
    rdc("high", 12'h008, 8'h12);
    wr(12'h008, 8'h00); wr(12'h004, 8'hff); wr(12'h000, 8'h07);
    pulses(1);
    wr(12'h000, 8'h00);
    rdc("carry low", 12'h004, 8'h00);
    rdc("carry high", 12'h008, 8'h01);
  endtask
  task t_trst;
    wr(12'h008, 8'h00); wr(12'h004, 8'h00); wr(12'h000, 8'h03);
    pulses(3);
    rdc("sync count", 12'h004, 8'h03);
    kick();
    rdc("trig reset", 12'h004, 8'h00);
    wr(12'h000, 8'h43);
    pulses(3);
    kick();
    rdc("reset blocked", 12'h004, 8'h03);
  endtask
  task t_sleep;
    wr(12'h000, 8'h00); wr(12'h004, 8'h00); wr(12'h00c, 8'h05); wr(12'h010, 8'h00);
    sleep <= 1;
    t0 = wakes;
    wr(12'h000, 8'h87);
    pulses(6);
    chk("wake", t0 + 1, wakes);
    t0 = trigs;
    wr(12'h000, 8'h07);
    pulses(6);
    wr(12'h000, 8'h85);
    repeat (40) @(posedge clk);
    wr(12'h000, 8'h83);
    pulses(6);
    chk("sleep stop", t0, trigs);
    sleep <= 0;
  endtask
  task t_count;
    wr(12'h000, 8'h00); wr(12'h004, 8'h00); wr(12'h00c, 8'h03); wr(12'h018, 8'h01);
    for (int p = 0; p < 4; p++) begin
      wr(12'h000, {p[1:0], 3'b001});
      gap();
      gap();
      chk("gap", 16 << p, n);
    end
    wr(12'h000, 8'h00);
    chk_irq(1);
    wr(12'h018, 8'h00);
    chk_irq(0);
    wr(12'h018, 8'h01);
    rdc("flag", 12'h014, 8'h01);
    chk_irq(0);
  endtask
  task t_oneshot;
    wr(12'h004, 8'h00); wr(12'h000, 8'h21);
    gap();
    rdc("one shot", 12'h000, 8'h20);
    t0 = trigs;
    repeat (40) @(posedge clk);
    rdc("held", 12'h004, 8'h00);
    chk("no rerun", t0, trigs);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    t_regs(); t_bytes(); t_trst(); t_sleep(); t_count(); t_oneshot();
    give_verdict();
  end
endmodule
`default_nettype wire
